//--- rtl/i2c_master_defines.svh
`ifndef I2C_MASTER_DEFINES_SVH
`define I2C_MASTER_DEFINES_SVH

// word indexes on the register bus
`define OFF_BUF 3'h0
`define OFF_CTRL 3'h1
`define OFF_STAT 3'h2
`define OFF_RELOAD 3'h3
`define OFF_IRQ_ST 3'h4
`define OFF_IRQ_CLR 3'h5
`define OFF_IRQ_EN 3'h6

// serial_control_two fields
`define CTRL_START 0
`define CTRL_RESTART 1
`define CTRL_STOP 2
`define CTRL_ACK 3
`define CTRL_RECV 4
`define CTRL_ACKDATA 5
`define CTRL_REQ_MASK 6'h1f
`define CTRL_RST 6'h00

// status fields
`define STAT_FULL 0
`define STAT_WR_COLL 1
`define STAT_START 2
`define STAT_STOP 3
`define STAT_ACKSTAT 4
`define STAT_BUSY 5

// interrupt status, clear and enable fields
`define IRQ_PORT 0
`define IRQ_BCOL 1
`define IRQ_WR_COLL 2
`define IRQ_RST 3'h0

`define RELOAD_RST 8'h13
`define SYNC_RST 3'h7

// last bit index of each of the three engines
`define LAST_TX_BIT 4'h8
`define LAST_RX_BIT 4'h7
`define LAST_ACK_BIT 4'h0

`endif

//--- rtl/i2c_coll_pkg.sv
package i2c_coll_pkg;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_START1 = 4'h1,
    ST_START2 = 4'h3,
    ST_BIT_LOW = 4'h2,
    ST_BIT_HIGH = 4'h6,
    ST_STOP1 = 4'h7,
    ST_STOP2 = 4'h5,
    ST_RSTART = 4'h4,
    ST_RST_HI = 4'hc
  } state_t;

  typedef enum logic [1:0] {
    OP_TX = 2'h0,
    OP_RX = 2'h1,
    OP_ACK = 2'h2
  } op_t;

endpackage : i2c_coll_pkg

//--- rtl/pin_filter.sv
`timescale 1ns/1ns
`include "i2c_master_defines.svh"

module pin_filter (
  input wire logic clk,
  input wire logic reset,
  input wire logic pin,
  output logic level,
  output logic rise,
  output logic fall
);

  logic [2:0] sync_r;
  logic level_r;
  // a change counts only once the second and third stages agree
  wire agree = sync_r[1] == sync_r[2];

  always_ff @(posedge clk) begin
    if (reset) begin
      sync_r <= `SYNC_RST;
      level_r <= 1'b1;
    end else begin
      sync_r <= {sync_r[1:0], pin};
      if (agree) begin
        level_r <= sync_r[2];
      end
    end
  end

  assign level = level_r;
  assign rise = agree & sync_r[2] & ~level_r;
  assign fall = agree & ~sync_r[2] & level_r;

endmodule : pin_filter

//--- rtl/i2c_master_collision_handler.sv
// The implementer's own choices: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`include "i2c_master_defines.svh"

module i2c_master_collision_handler
  import i2c_coll_pkg::*;
#(
  parameter int BAUD_W = 8
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [2:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output logic irq
);

  state_t state_r, state_nxt;
  op_t op_r, op_nxt;
  logic [BAUD_W-1:0] baud_counter_r, reload_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] shift_r, rx_r;
  logic [5:0] ctrl_r;
  logic [2:0] irq_st_r, irq_en_r;
  logic ack_r, sampled_r, hold_scl_r, full_r, ackstat_r;
  logic start_seen_r, stop_seen_r, scl_oe_r, sda_oe_r;
  logic [31:0] readdata_r;
  logic scl_lvl, scl_rise, scl_fall, sda_lvl, sda_rise, sda_fall;

  pin_filter u_scl (
    .clk(clk),
    .reset(reset),
    .pin(scl_i),
    .level(scl_lvl),
    .rise(scl_rise),
    .fall(scl_fall)
  );

  pin_filter u_sda (
    .clk(clk),
    .reset(reset),
    .pin(sda_i),
    .level(sda_lvl),
    .rise(sda_rise),
    .fall(sda_fall)
  );

  // bus slave: one wait cycle, action on the edge that sees waitrequest low
  wire req = read | write;
  wire bus_wr = write & ack_r;
  wire bus_rd = read & ack_r;
  wire wr_buf = bus_wr & (address == `OFF_BUF);
  wire wr_ctrl = bus_wr & (address == `OFF_CTRL);
  wire wr_reload = bus_wr & (address == `OFF_RELOAD);
  wire wr_clr = bus_wr & (address == `OFF_IRQ_CLR);
  wire wr_en = bus_wr & (address == `OFF_IRQ_EN);
  wire rd_buf = bus_rd & (address == `OFF_BUF);

  wire idle = state_r == ST_IDLE;
  wire buf_ok = wr_buf & idle;
  wire wr_coll_evt = wr_buf & ~idle;

  // clock released by us but held low elsewhere: counter waits
  wire scl_rel = (state_r == ST_BIT_HIGH) | (state_r == ST_RST_HI) | (state_r == ST_STOP2);
  wire hold_low = scl_rel & ~scl_lvl;
  wire tick = (baud_counter_r == '0) & ~hold_low;

  wire [3:0] last_cnt = (op_r == OP_TX) ? `LAST_TX_BIT :
                        (op_r == OP_RX) ? `LAST_RX_BIT : `LAST_ACK_BIT;
  wire last_bit = bit_cnt_r == last_cnt;
  wire ack_in = (op_r == OP_TX) & (bit_cnt_r == `LAST_TX_BIT);
  wire cur_one = (op_r == OP_RX) | ack_in |
                 ((op_r == OP_TX) & shift_r[7]) |
                 ((op_r == OP_ACK) & ctrl_r[`CTRL_ACKDATA]);
  wire sample = (state_r == ST_BIT_HIGH) & scl_lvl & ~sampled_r;

  // we released the data line for a one, yet it reads low
  wire coll_bit = sample & cur_one & ~sda_lvl & ~ack_in & (op_r != OP_RX);
  wire coll_start = (state_r == ST_START1) & (~scl_lvl | ~sda_lvl);
  wire coll_rst = (state_r == ST_RST_HI) & scl_lvl & ~sda_lvl;
  wire coll = coll_bit | coll_start | coll_rst;

  wire byte_done = (state_r == ST_BIT_HIGH) & tick & last_bit & ~coll;
  wire start_done = (state_r == ST_START2) & tick;
  wire stop_done = (state_r == ST_STOP2) & tick;
  wire bus_start = sda_fall & scl_lvl & ~scl_fall;
  wire bus_stop = sda_rise & scl_lvl & ~scl_fall; // our data edge lands with clock fall
  // bus is watched in every state, so a foreign stop after a loss still interrupts
  wire port_evt = byte_done | start_done | stop_done | bus_stop;

  always_comb begin
    state_nxt = state_r;
    op_nxt = op_r;
    if (coll) begin
      state_nxt = ST_IDLE;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (buf_ok) begin
            state_nxt = ST_BIT_LOW;
            op_nxt = OP_TX;
          end else if (ctrl_r[`CTRL_START]) begin
            state_nxt = ST_START1;
          end else if (ctrl_r[`CTRL_RESTART]) begin
            state_nxt = ST_RSTART;
          end else if (ctrl_r[`CTRL_STOP]) begin
            state_nxt = ST_STOP1;
          end else if (ctrl_r[`CTRL_ACK]) begin
            state_nxt = ST_BIT_LOW;
            op_nxt = OP_ACK;
          end else if (ctrl_r[`CTRL_RECV]) begin
            state_nxt = ST_BIT_LOW;
            op_nxt = OP_RX;
          end
        end
        ST_START1: if (tick) state_nxt = ST_START2;
        ST_START2: if (tick) state_nxt = ST_IDLE;
        ST_RSTART: if (tick) state_nxt = ST_RST_HI;
        ST_RST_HI: if (tick) state_nxt = ST_START2;
        ST_BIT_LOW: if (tick) state_nxt = ST_BIT_HIGH;
        ST_BIT_HIGH: if (tick) state_nxt = last_bit ? ST_IDLE : ST_BIT_LOW;
        ST_STOP1: if (tick) state_nxt = ST_STOP2;
        ST_STOP2: if (tick) state_nxt = ST_IDLE;
        default: state_nxt = ST_IDLE;
      endcase
    end
  end

  wire next_bit = (state_r == ST_BIT_HIGH) & (state_nxt == ST_BIT_LOW);
  wire leave = state_nxt != state_r;

  always_ff @(posedge clk) begin
    if (reset) begin
      state_r <= ST_IDLE;
      op_r <= OP_TX;
    end else begin
      state_r <= state_nxt;
      op_r <= op_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      baud_counter_r <= '0;
    end else if (leave | hold_low) begin
      baud_counter_r <= reload_r;
    end else if (baud_counter_r != '0) begin
      baud_counter_r <= baud_counter_r - 1'b1;
    end
  end

  // count restarts whenever the engine leaves the bit states
  always_ff @(posedge clk) begin
    if (reset) begin
      bit_cnt_r <= 4'h0;
    end else if (next_bit) begin
      bit_cnt_r <= bit_cnt_r + 4'h1;
    end else if (state_r != ST_BIT_HIGH && state_r != ST_BIT_LOW) begin
      bit_cnt_r <= 4'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      sampled_r <= 1'b0;
    end else begin
      sampled_r <= (state_r == ST_BIT_HIGH) & (sampled_r | sample) & ~leave;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      shift_r <= 8'h00;
    end else if (buf_ok) begin
      shift_r <= writedata[7:0];
    end else if (sample && op_r == OP_RX) begin
      shift_r <= {shift_r[6:0], sda_lvl};
    end else if (next_bit && op_r == OP_TX) begin
      shift_r <= {shift_r[6:0], 1'b0};
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rx_r <= 8'h00;
      ackstat_r <= 1'b0;
    end else begin
      if (byte_done && op_r == OP_RX) begin
        rx_r <= shift_r;
      end
      if (sample && ack_in) begin
        ackstat_r <= sda_lvl;
      end
    end
  end

  // setting wins over a read or collision in the same cycle
  wire full_set = buf_ok | (byte_done & (op_r == OP_RX));
  wire full_clr = coll | (byte_done & (op_r == OP_TX)) | rd_buf;
  always_ff @(posedge clk) begin
    if (reset) begin
      full_r <= 1'b0;
    end else begin
      full_r <= full_set | (full_r & ~full_clr);
    end
  end

  wire hold_set = start_done | byte_done;
  wire hold_clr = coll | (idle & leave);
  always_ff @(posedge clk) begin
    if (reset) begin
      hold_scl_r <= 1'b0;
    end else begin
      hold_scl_r <= ~hold_clr & (hold_set | hold_scl_r);
    end
  end

  wire [5:0] done_clr = {1'b0,
                         byte_done & (op_r == OP_RX),
                         byte_done & (op_r == OP_ACK),
                         stop_done, start_done, start_done};
  wire [5:0] ctrl_clr = coll ? `CTRL_REQ_MASK : done_clr;
  wire [5:0] ctrl_set = wr_ctrl ? writedata[5:0] : 6'h00;
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_r <= `CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_r <= ctrl_set | (ctrl_r & ~ctrl_clr & ~`CTRL_REQ_MASK);
    end else begin
      ctrl_r <= ctrl_r & ~ctrl_clr;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      reload_r <= BAUD_W'(`RELOAD_RST);
    end else if (wr_reload) begin
      reload_r <= writedata[BAUD_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      start_seen_r <= 1'b0;
      stop_seen_r <= 1'b0;
    end else if (bus_stop) begin
      start_seen_r <= 1'b0;
      stop_seen_r <= 1'b1;
    end else if (bus_start) begin
      start_seen_r <= 1'b1;
      stop_seen_r <= 1'b0;
    end
  end

  wire [2:0] irq_set = {wr_coll_evt, coll, port_evt};
  wire [2:0] irq_clr = wr_clr ? writedata[2:0] : 3'h0;
  always_ff @(posedge clk) begin
    if (reset) begin
      irq_st_r <= `IRQ_RST;
      irq_en_r <= `IRQ_RST;
    end else begin
      irq_st_r <= irq_set | (irq_st_r & ~irq_clr);
      if (wr_en) begin
        irq_en_r <= writedata[2:0];
      end
    end
  end

  // pin drive is registered; a lost line is let go one cycle after the loss
  wire in_bit = (state_r == ST_BIT_LOW) | (state_r == ST_BIT_HIGH);
  wire scl_want = (state_r == ST_BIT_LOW) | (state_r == ST_STOP1) |
                  (state_r == ST_RSTART) | (idle & hold_scl_r);
  wire sda_want = (state_r == ST_START2) | (state_r == ST_STOP1) |
                  (state_r == ST_STOP2) | (in_bit & ~cur_one);
  always_ff @(posedge clk) begin
    if (reset) begin
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end else begin
      scl_oe_r <= scl_want & ~coll;
      sda_oe_r <= sda_want & ~coll;
    end
  end

  wire [5:0] stat = {~idle, ackstat_r, start_seen_r, stop_seen_r,
                     irq_st_r[`IRQ_WR_COLL], full_r};
  wire [31:0] rd_mux =
    (address == `OFF_BUF) ? {24'h000000, rx_r} :
    (address == `OFF_CTRL) ? {26'h0000000, ctrl_r} :
    (address == `OFF_STAT) ? {26'h0000000, stat} :
    (address == `OFF_RELOAD) ? 32'(reload_r) :
    (address == `OFF_IRQ_ST) ? {29'h00000000, irq_st_r} :
    (address == `OFF_IRQ_EN) ? {29'h00000000, irq_en_r} : 32'h00000000;

  always_ff @(posedge clk) begin
    if (reset) begin
      ack_r <= 1'b0;
      readdata_r <= 32'h00000000;
    end else begin
      ack_r <= req & ~ack_r;
      if (read & ~ack_r) begin
        readdata_r <= rd_mux;
      end
    end
  end

  assign waitrequest = req & ~ack_r;
  assign readdata = readdata_r;
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe = scl_oe_r;
  assign sda_oe = sda_oe_r;
  assign irq = |(irq_st_r & irq_en_r);

endmodule : i2c_master_collision_handler

//--- verification/i2c_bus_model.sv
`timescale 1ns/1ns
module i2c_bus_model (
  input wire logic scl_oe,
  input wire logic sda_oe,
  input wire logic hold_scl,
  input wire logic hold_sda,
  output logic scl_i,
  output logic sda_i
);
  // pull-ups: a released line reads high, any party pulling low wins
  assign scl_i = !(scl_oe || hold_scl);
  assign sda_i = !(sda_oe || hold_sda);
endmodule : i2c_bus_model

//--- verification/i2c_coll_chk.sv
`timescale 1ns/1ns
module i2c_coll_chk (
  input wire logic clk,
  input wire logic reset,
  input wire logic [2:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic scl_i,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  // five cycles cover the pin filter lag
  sequence line_low;
    !scl_oe && !sda_oe && (!scl_i || !sda_i) [*5];
  endsequence
  sequence scl_held;
    !scl_oe && !scl_i [*5];
  endsequence
  AST_WAIT_FIRST: assert property ($rose(read || write) |-> waitrequest)
    else $error("no wait cycle");
  AST_WAIT_ONE: assert property ((read || write) && waitrequest |=> !waitrequest || !(read || write))
    else $error("wait too long");
  AST_WAIT_IDLE: assert property (!(read || write) |-> !waitrequest)
    else $error("wait without request");
  AST_OPEN_DRAIN: assert property (!scl_o && !sda_o)
    else $error("line driven high");
  AST_GAP_ZERO: assert property (read && !waitrequest && address == 3'h7 |-> readdata == 32'h0)
    else $error("unmapped read not zero");
  AST_UPPER_ZERO: assert property (read && !waitrequest |-> readdata[31:8] == 24'h0)
    else $error("upper bits set");
  AST_START_GUARD: assert property (line_low |=> !($rose(sda_oe) && !scl_oe))
    else $error("start on busy bus");
  AST_STRETCH: assert property (scl_held |=> !scl_oe)
    else $error("clock not stretched");
endmodule : i2c_coll_chk

bind i2c_master_collision_handler i2c_coll_chk i2c_coll_chk_i (.clk, .reset, .address, .read,
  .write, .readdata, .waitrequest, .scl_i, .scl_o, .scl_oe, .sda_i, .sda_o, .sda_oe);

//--- verification/tb_top.sv
`timescale 1ns/1ns
`include "i2c_master_defines.svh"
module tb_top;
  logic clk, reset, read, write, scl_i, sda_i, scl_o, sda_o, scl_oe, sda_oe, irq, waitrequest;
  logic hold_scl, hold_sda, scl_q;
  logic [2:0] address;
  logic [31:0] writedata, readdata, d;
  logic [15:0] bits;
  int nbits, b0, err_total, tests_run, cyc;
  i2c_master_collision_handler i2c_master_collision_handler_i (.clk, .reset, .address, .read,
    .write, .writedata, .readdata, .waitrequest, .scl_i, .scl_o, .scl_oe, .sda_i, .sda_o,
    .sda_oe, .irq);
  i2c_bus_model i2c_bus_model_i (.scl_oe, .sda_oe, .hold_scl, .hold_sda, .scl_i, .sda_i);
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  task give_verdict;
    $display("mismatches %0d comparisons %0d", err_total, tests_run);
    if (err_total == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : give_verdict
  // bits are taken from the wire at each clock-line rise
  always @(posedge clk) begin
    cyc <= cyc + 1;
    scl_q <= scl_i;
    if (scl_i && !scl_q) begin
      bits <= {bits[14:0], sda_i};
      nbits <= nbits + 1;
    end
    if (cyc == 40000) begin
      err_total++;
      give_verdict();
    end
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // the master never counts on the wait; only the bench timeout ends a hung access
  task acc(input logic wr, input logic [2:0] a, input logic [31:0] v);
    address <= a;
    writedata <= v;
    read <= !wr;
    write <= wr;
    do begin
      @(posedge clk);
    end while (waitrequest !== 1'b0);
    d = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask : acc
  task poll(input logic [2:0] a, input int b, input logic v);
    int n;
    n = 0;
    do begin
      acc(0, a, 0);
      n++;
    end while (d[b] !== v && n < 400);
    chk(32'(d[b]), 32'(v));
  endtask : poll
  initial begin
    {reset, read, write, address, writedata, hold_scl, hold_sda} = {3'h4, 35'h0, 2'h0};
    {scl_q, bits, nbits, err_total, tests_run, cyc} = {17'h10000, 128'h0};
    repeat (4) @(posedge clk);
    reset <= 0;
    @(posedge clk);
    acc(0, `OFF_RELOAD, 0);
    chk(d, 32'h13);
    acc(0, `OFF_IRQ_EN, 0);
    chk(d, 32'h0);
    acc(1, 3'h7, 32'hff);
    acc(0, 3'h7, 0);
    chk(d, 32'h0);
    acc(1, `OFF_RELOAD, 32'h4);
    acc(1, `OFF_IRQ_EN, 32'h7);
    acc(1, `OFF_CTRL, 32'h1);
    poll(`OFF_CTRL, `CTRL_START, 0);
    b0 = nbits;
    acc(1, `OFF_BUF, 32'ha5);
    acc(1, `OFF_BUF, 32'h3c);
    acc(0, `OFF_STAT, 0);
    chk(32'(d[`STAT_WR_COLL]), 32'h1);
    poll(`OFF_STAT, `STAT_BUSY, 0);
    chk(32'(bits[8:1]), 32'ha5);
    chk(32'(irq), 32'h1);
    acc(1, `OFF_IRQ_EN, 0);
    chk(32'(irq), 32'h0);
    acc(1, `OFF_IRQ_CLR, 32'h7);
    acc(1, `OFF_IRQ_EN, 32'h7);
    chk(32'(irq), 32'h0);
    acc(1, `OFF_CTRL, 32'h4);
    poll(`OFF_CTRL, `CTRL_STOP, 0);
    acc(1, `OFF_CTRL, 32'h1);
    poll(`OFF_CTRL, `CTRL_START, 0);
    acc(1, `OFF_IRQ_CLR, 32'h7);
    b0 = nbits;
    acc(1, `OFF_BUF, 32'h7f);
    acc(1, `OFF_CTRL, 32'h4);
    while (nbits - b0 < 1) @(posedge clk);
    while (scl_oe !== 1'b1) @(posedge clk);
    hold_sda <= 1;
    poll(`OFF_STAT, `STAT_BUSY, 0);
    chk(32'(d[`STAT_FULL]), 32'h0);
    chk({30'h0, scl_oe, sda_oe}, 32'h0);
    acc(0, `OFF_CTRL, 0);
    chk(d, 32'h0);
    acc(0, `OFF_IRQ_ST, 0);
    chk(32'(d[1:0]), 32'h2);
    hold_sda <= 0;
    poll(`OFF_IRQ_ST, `IRQ_PORT, 1);
    // bus is free again, so software resumes with a fresh start
    acc(1, `OFF_CTRL, 32'h1);
    poll(`OFF_CTRL, `CTRL_START, 0);
    b0 = nbits;
    acc(1, `OFF_BUF, 32'h7f);
    while (nbits - b0 < 3) @(posedge clk);
    while (scl_oe !== 1'b1) @(posedge clk);
    hold_scl <= 1;
    repeat (20) @(posedge clk);
    hold_scl <= 0;
    poll(`OFF_STAT, `STAT_BUSY, 0);
    chk(32'(nbits - b0), 32'h9);
    chk(32'(bits[8:1]), 32'h7f);
    // released ack bit held low elsewhere: collision, ack request dropped, data bit kept
    acc(1, `OFF_IRQ_CLR, 32'h7);
    hold_sda <= 1'b1;
    acc(1, `OFF_CTRL, 32'h28);
    poll(`OFF_CTRL, `CTRL_ACK, 0);
    chk(d, 32'h20);
    acc(0, `OFF_IRQ_ST, 0);
    chk(32'(d[`IRQ_BCOL]), 32'h1);
    hold_sda <= 1'b0;
    acc(1, `OFF_CTRL, 32'h4);
    poll(`OFF_CTRL, `CTRL_STOP, 0);
    for (int k = 0; k < 2; k++) begin
      hold_scl <= (k == 0);
      hold_sda <= (k == 1);
      acc(1, `OFF_IRQ_CLR, 32'h7);
      acc(1, `OFF_CTRL, 32'h1);
      poll(`OFF_CTRL, `CTRL_START, 0);
      acc(0, `OFF_IRQ_ST, 0);
      chk(32'(d[`IRQ_BCOL]), 32'h1);
      chk({30'h0, scl_oe, sda_oe}, 32'h0);
      hold_scl <= 0;
      hold_sda <= 0;
      repeat (8) @(posedge clk);
    end
    // another master's frame, clock period 160 ns
    hold_sda <= 1;
    repeat (8) @(posedge clk);
    repeat (4) begin
      hold_scl <= 1;
      repeat (8) @(posedge clk);
      hold_scl <= 0;
      repeat (8) @(posedge clk);
    end
    hold_sda <= 0;
    poll(`OFF_STAT, `STAT_STOP, 1);
    acc(1, `OFF_IRQ_CLR, 32'h7);
    acc(1, `OFF_CTRL, 32'h1);
    poll(`OFF_CTRL, `CTRL_START, 0);
    acc(0, `OFF_IRQ_ST, 0);
    chk(32'(d[`IRQ_BCOL]), 32'h0);
    give_verdict();
  end
endmodule : tb_top
